// [logic/hrc_map.svh]
`ifndef HRC_MAP_SVH
`define HRC_MAP_SVH

// Register byte offsets
`define HRC_OFF_COUNT 12'h000
`define HRC_OFF_MATCH0 12'h004
`define HRC_OFF_MATCH1 12'h008
`define HRC_OFF_LOAD 12'h00c
`define HRC_OFF_CTL 12'h010
`define HRC_OFF_MASK 12'h014
`define HRC_OFF_RAW 12'h018
`define HRC_OFF_MSKD 12'h01c
`define HRC_OFF_CLR 12'h020
`define HRC_OFF_TRIM 12'h024
// Retained memory word index window (byte 0x030 to 0x12c)
`define HRC_MEM_FIRST 10'h00c
`define HRC_MEM_LAST 10'h04b

// Control bit positions
`define HRC_CTL_CNT_EN 0
`define HRC_CTL_HIB_REQ 1
`define HRC_CTL_CLK_SEL 2
`define HRC_CTL_MATCH_WEN 3
`define HRC_CTL_PIN_WEN 4
`define HRC_CTL_CLK_EN 6
`define HRC_CTL_ABORT 7
`define HRC_CTL_LB_EN 9
`define HRC_CTL_RW_MASK 32'h0000_02dd

// Event bit positions
`define HRC_EV_MATCH0 0
`define HRC_EV_MATCH1 1
`define HRC_EV_FLAG_A 2
`define HRC_EV_WAKE 3

// Reset values
`define HRC_RST_MATCH 32'hffff_ffff
`define HRC_RST_LOAD 32'hffff_ffff
`define HRC_RST_CTL 32'h8000_0000
`define HRC_RST_TRIM 16'h7fff

// Timing counts
`define HRC_PREDIV_NOMINAL 16'h7fff
`define HRC_XTAL_DIV_LAST 7'h7f
`define HRC_TRIM_SLOT 6'h3f

// Bus answers
`define HRC_RESP_OKAY 2'h0
`define HRC_RESP_SLVERR 2'h2

`endif

// [logic/hrc_pkg.sv]
package hrc_pkg;
    // Power sequencing state
    typedef enum logic [0:0] {
        HRC_AWAKE = 1'b0,
        HRC_ASLEEP = 1'b1
    } hrc_pwr_t;
endpackage

// [logic/hrc_top.sv]
`timescale 1ns/1ns
// What this block does
// - Low battery sets raw flag when detect enabled
// - Abort and detect enable bits plus low battery refuse hibernation
// - No battery detection while hibernated
// - 32-bit seconds counter steps once per second
// - Predivider counts reference ticks down to second
// - Trim count used one second in 64
// - Larger trim slows, smaller trim speeds counter
// - Two match compares wake or interrupt
// - Counter advances only while counter enable set
// - Load write sets counter immediately
// - 64 retained 32-bit words for software
// - Regulator output low in hibernation, high on wake
// - Wake by pin or match per enables
// - Wake event stays pending in raw status
// - Record wake pin, match, low battery events
// - Enabled pending events ORed onto one interrupt
// - Mask gates interrupt; masked status shows them
// - Raw status shows all events, always readable
// - Writing one to clear bit clears event
// - Select bit picks crystal/128 or direct oscillator
// - Reference runs block only when clock enabled
`include "hrc_map.svh"
module hrc_top #(
    parameter int MEM_WORDS = 64
) (
    input wire logic aclk, // System clock, 100 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic ref_osc_in, // Direct 32.768 kHz oscillator pin
    input wire logic ref_xtal_in, // Fast crystal clock pin
    input wire logic wake_n_in, // Wake pin, active low
    input wire logic battery_low_in, // Low battery comparator pin
    output logic regulator_enable_n, // Low cuts system power
    output logic irq // Combined interrupt request
);
    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge for partial writes; each strobe bit widens to a full lane
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        return (old & ~{{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}})
               | (nw & {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}});
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic aw_got_r, w_got_r, bvalid_r, awready_r, wready_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [11:0] aw_addr_r, ar_addr_r;
    logic [31:0] wdata_r, rdata_r, count_r, match0_r, match1_r, load_r, ctl_r;
    logic [3:0] wstrb_r, mask_r, raw_r;
    logic [15:0] trim_r, prediv_r;
    logic [5:0] sec64_r;
    logic [6:0] xdiv_r;
    logic osc_s1_r, osc_s2_r, osc_s3_r, xtal_s1_r, xtal_s2_r, xtal_s3_r, reg_en_n_r, irq_r;
    logic wake_s1_r, wake_s2_r, wake_s3_r, bat_s1_r, bat_s2_r, eq0_q_r, eq1_q_r;
    hrc_pkg::hrc_pwr_t pwr_r, pwr_nxt;
    logic [31:0] mem_r [MEM_WORDS];
    ////////////////////////////////////////////////////////////////////////////
    // Bus handshakes and address decode
    wire aw_hs = s_axi_awvalid & awready_r;
    wire w_hs = s_axi_wvalid & wready_r;
    wire ar_hs = s_axi_arvalid & arready_r;
    wire do_write = aw_got_r & w_got_r & ~bvalid_r;
    wire [9:0] w_word = aw_addr_r[11:2];
    wire [9:0] r_word = ar_addr_r[11:2];
    wire w_mem = (w_word >= `HRC_MEM_FIRST) & (w_word <= `HRC_MEM_LAST);
    wire r_mem = (r_word >= `HRC_MEM_FIRST) & (r_word <= `HRC_MEM_LAST);
    wire [5:0] w_idx = 6'(w_word - `HRC_MEM_FIRST);
    wire [5:0] r_idx = 6'(r_word - `HRC_MEM_FIRST);
    wire wr_match0 = do_write & (aw_addr_r == `HRC_OFF_MATCH0);
    wire wr_match1 = do_write & (aw_addr_r == `HRC_OFF_MATCH1);
    wire wr_load = do_write & (aw_addr_r == `HRC_OFF_LOAD);
    wire wr_ctl = do_write & (aw_addr_r == `HRC_OFF_CTL);
    wire wr_mask = do_write & (aw_addr_r == `HRC_OFF_MASK);
    wire wr_clr = do_write & (aw_addr_r == `HRC_OFF_CLR);
    wire wr_trim = do_write & (aw_addr_r == `HRC_OFF_TRIM);
    wire wr_mem = do_write & w_mem;
    // Read-only registers take writes silently; only holes answer with an error
    wire w_known = w_mem | (aw_addr_r <= `HRC_OFF_TRIM);
    wire r_known = r_mem | (ar_addr_r <= `HRC_OFF_TRIM);
    wire [31:0] load_nxt = merge(load_r, wdata_r, wstrb_r);
    wire [31:0] ctl_wr = merge(ctl_r, wdata_r, wstrb_r);
    wire [31:0] trim_wr = merge({16'h0000, trim_r}, wdata_r, wstrb_r);
    wire [31:0] mem_wr = merge(mem_r[w_idx], wdata_r, wstrb_r);
    wire [3:0] clr_bits = (wr_clr && wstrb_r[0]) ? wdata_r[3:0] : 4'h0;
    wire [31:0] mask_wr = merge({28'h0000000, mask_r}, wdata_r, wstrb_r);
    wire [3:0] mask_nxt = wr_mask ? mask_wr[3:0] : mask_r;
    ////////////////////////////////////////////////////////////////////////////
    // Control fields
    wire cnt_en = ctl_r[`HRC_CTL_CNT_EN];
    wire clk_sel = ctl_r[`HRC_CTL_CLK_SEL];
    wire clk_en = ctl_r[`HRC_CTL_CLK_EN];
    wire match_wake_enable = ctl_r[`HRC_CTL_MATCH_WEN];
    wire pin_wake_enable = ctl_r[`HRC_CTL_PIN_WEN];
    wire flag_a_detect_enable = ctl_r[`HRC_CTL_LB_EN];
    wire abort_on_flag_a = ctl_r[`HRC_CTL_ABORT];
    ////////////////////////////////////////////////////////////////////////////
    // Reference tick from the selected, enabled source
    wire osc_rise = osc_s2_r & ~osc_s3_r;
    wire xtal_rise = xtal_s2_r & ~xtal_s3_r;
    wire ref_tick = clk_en & (clk_sel ? osc_rise :
                    (xtal_rise & (xdiv_r == `HRC_XTAL_DIV_LAST)));
    // A zero predivider completes a second; trim replaces nominal once in 64
    wire sec_tick = cnt_en & ref_tick & (prediv_r == 16'h0000);
    wire [15:0] reload = (sec64_r == `HRC_TRIM_SLOT) ? trim_r : `HRC_PREDIV_NOMINAL;
    ////////////////////////////////////////////////////////////////////////////
    // Events: match on becoming equal, wake pin falling edge, low battery level
    wire eq0 = (count_r == match0_r);
    wire eq1 = (count_r == match1_r);
    wire m0_ev = eq0 & ~eq0_q_r;
    wire m1_ev = eq1 & ~eq1_q_r;
    wire wake_ev = ~wake_s2_r & wake_s3_r;
    wire bat_low = bat_s2_r;
    wire asleep = (pwr_r == hrc_pkg::HRC_ASLEEP);
    wire lb_ev = flag_a_detect_enable & bat_low & ~asleep;
    wire [3:0] ev_set = {wake_ev, lb_ev, m1_ev, m0_ev};
    wire [3:0] raw_nxt = (raw_r & ~clr_bits) | ev_set;
    wire [3:0] masked = raw_r & mask_r;
    ////////////////////////////////////////////////////////////////////////////
    // Hibernate request, abort and wake
    wire hib_req = wr_ctl & ctl_wr[`HRC_CTL_HIB_REQ];
    wire hib_abort = ctl_wr[`HRC_CTL_LB_EN] & ctl_wr[`HRC_CTL_ABORT] & bat_low;
    wire wake_now = (pin_wake_enable & wake_ev) |
                    (match_wake_enable & (m0_ev | m1_ev));
    // Power state sequencing
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            hrc_pkg::HRC_AWAKE: begin
                if (hib_req && !hib_abort) begin
                    pwr_nxt = hrc_pkg::HRC_ASLEEP;
                end
            end
            hrc_pkg::HRC_ASLEEP: begin
                if (wake_now) begin
                    pwr_nxt = hrc_pkg::HRC_AWAKE;
                end
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read data decode
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (r_mem) begin
            rd_val = mem_r[r_idx];
        end else begin
            unique case (ar_addr_r)
                `HRC_OFF_COUNT: rd_val = count_r;
                `HRC_OFF_MATCH0: rd_val = match0_r;
                `HRC_OFF_MATCH1: rd_val = match1_r;
                `HRC_OFF_LOAD: rd_val = load_r;
                `HRC_OFF_CTL: rd_val = ctl_r;
                `HRC_OFF_MASK: rd_val = {28'h0000000, mask_r};
                `HRC_OFF_RAW: rd_val = {28'h0000000, raw_r};
                `HRC_OFF_MSKD: rd_val = {28'h0000000, masked};
                `HRC_OFF_TRIM: rd_val = {16'h0000, trim_r};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `HRC_RESP_OKAY;
            aw_addr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_r <= 1'b1;
                awready_r <= 1'b0;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= w_known ? `HRC_RESP_OKAY : `HRC_RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end
    // Read channel: one cycle to latch the address, one to present data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `HRC_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            ar_addr_r <= 12'h000;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            ar_addr_r <= s_axi_araddr;
        end else if (!arready_r && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= r_known ? `HRC_RESP_OKAY : `HRC_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {osc_s1_r, osc_s2_r, osc_s3_r} <= 3'h0;
            {xtal_s1_r, xtal_s2_r, xtal_s3_r} <= 3'h0;
            {wake_s1_r, wake_s2_r, wake_s3_r} <= 3'h7;
            {bat_s1_r, bat_s2_r} <= 2'h0;
        end else begin
            {osc_s1_r, osc_s2_r, osc_s3_r} <= {ref_osc_in, osc_s1_r, osc_s2_r};
            {xtal_s1_r, xtal_s2_r, xtal_s3_r} <= {ref_xtal_in, xtal_s1_r, xtal_s2_r};
            {wake_s1_r, wake_s2_r, wake_s3_r} <= {wake_n_in, wake_s1_r, wake_s2_r};
            {bat_s1_r, bat_s2_r} <= {battery_low_in, bat_s1_r};
        end
    end
    // Crystal divide-by-128 and the predivider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xdiv_r <= 7'h00;
            prediv_r <= `HRC_PREDIV_NOMINAL;
            sec64_r <= 6'h00;
        end else begin
            if (clk_en && !clk_sel && xtal_rise) begin
                xdiv_r <= 7'(xdiv_r + 7'h01);
            end
            if (sec_tick) begin
                prediv_r <= reload;
                sec64_r <= 6'(sec64_r + 6'h01);
            end else if (cnt_en && ref_tick) begin
                prediv_r <= 16'(prediv_r - 16'h0001);
            end
        end
    end
    // Seconds counter; a load write wins over a same-cycle tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= 32'h0000_0000;
        end else if (wr_load) begin
            count_r <= load_nxt;
        end else if (sec_tick) begin
            count_r <= 32'(count_r + 32'h0000_0001);
        end
    end
    // Software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match0_r <= `HRC_RST_MATCH;
            match1_r <= `HRC_RST_MATCH;
            load_r <= `HRC_RST_LOAD;
            ctl_r <= `HRC_RST_CTL;
            mask_r <= 4'h0;
            trim_r <= `HRC_RST_TRIM;
        end else begin
            if (wr_match0) match0_r <= merge(match0_r, wdata_r, wstrb_r);
            if (wr_match1) match1_r <= merge(match1_r, wdata_r, wstrb_r);
            if (wr_load) load_r <= load_nxt;
            // Request bit never stored: it only launches the sequence
            if (wr_ctl) begin
                ctl_r <= (ctl_wr & `HRC_CTL_RW_MASK & ~(32'h1 << `HRC_CTL_HIB_REQ))
                         | `HRC_RST_CTL;
            end
            mask_r <= mask_nxt;
            if (wr_trim) trim_r <= trim_wr[15:0];
        end
    end
    // Retained memory has no reset so it keeps contents across hibernation
    always_ff @(posedge aclk) begin
        if (wr_mem) begin
            mem_r[w_idx] <= mem_wr;
        end
    end
    // Event status, power state and registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eq0_q_r <= 1'b0;
            eq1_q_r <= 1'b0;
            raw_r <= 4'h0;
            pwr_r <= hrc_pkg::HRC_AWAKE;
            reg_en_n_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            eq0_q_r <= eq0;
            eq1_q_r <= eq1;
            raw_r <= raw_nxt;
            pwr_r <= pwr_nxt;
            reg_en_n_r <= (pwr_nxt != hrc_pkg::HRC_ASLEEP);
            irq_r <= |(raw_nxt & mask_nxt);
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign regulator_enable_n = reg_en_n_r;
    assign irq = irq_r;
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    flag_a_flag_a: assert property (lb_ev |=> raw_r[`HRC_EV_FLAG_A])
        else $error("low battery flag not set");
    hib_abort_a: assert property (!asleep && hib_req && hib_abort |=> !asleep)
        else $error("hibernation entered despite low battery abort");
    no_flag_a_hib_a: assert property (asleep && !raw_r[`HRC_EV_FLAG_A]
        |=> !raw_r[`HRC_EV_FLAG_A])
        else $error("low battery detected while hibernated");
    count_step_a: assert property (sec_tick && !wr_load
        |=> count_r == $past(count_r) + 32'h1)
        else $error("seconds counter did not step by one");
    prediv_reload_a: assert property (sec_tick && sec64_r == `HRC_TRIM_SLOT
        |=> prediv_r == $past(trim_r) && sec64_r == 6'h00)
        else $error("trim count not used in slot second");
    hold_count_a: assert property (!cnt_en && !wr_load |=> $stable(count_r))
        else $error("counter moved while disabled");
    load_set_a: assert property (wr_load |=> count_r == $past(load_nxt))
        else $error("load write did not set counter");
    match_wake_a: assert property (asleep && match_wake_enable && (m0_ev || m1_ev)
        |=> !asleep && regulator_enable_n)
        else $error("match did not wake");
    reg_cut_a: assert property (regulator_enable_n == !asleep)
        else $error("regulator output disagrees with power state");
    irq_or_a: assert property (irq == |(raw_r & mask_r))
        else $error("enabled pending event without interrupt");
    clear_a: assert property (wr_clr && wstrb_r[0] && wdata_r[`HRC_EV_WAKE] && !wake_ev
        |=> !raw_r[`HRC_EV_WAKE])
        else $error("clear write left wake flag set");
endmodule

// [tb/hrc_supply_model.sv]
`timescale 1ns/1ns
// Stands in for the external regulator and the wake pin with its pull-up
module hrc_supply_model (
    input wire logic aclk, // System clock
    input wire logic regulator_enable_n, // Regulator enable from the block
    input wire logic press, // One-cycle request for a wake pin press
    output logic wake_n_in, // Wake pin, pulled up while idle
    output logic power_good // Rail state seen by the system
);
    logic [3:0] hold_r = 4'h0;
    logic rail_r = 1'b1;
    // A press is held low well past the synchroniser depth so it is never missed
    always @(posedge aclk) begin
        if (press) begin
            hold_r <= 4'h8;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end
    // Pull-up takes the pin high whenever nobody presses
    assign wake_n_in = (hold_r == 4'h0);
    // Rail follows the enable one cycle late, like a slow regulator
    always @(posedge aclk) rail_r <= regulator_enable_n;
    assign power_good = rail_r;
endmodule

// [tb/hrc_top_tb.sv]
`timescale 1ns/1ns
`include "hrc_map.svh"
module hrc_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, m, r;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic battery_low_in, press, wake_n_in, power_good, regulator_enable_n, irq;
    logic ref_osc_in = 1'b0;
    logic [2:0] osc_cnt = 3'h0;
    logic [31:0] mem_d [4];
    logic [5:0] mem_i [4];
    logic [31:0] rst_v [8] = '{32'h0, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'h8000_0000, 32'h0, 32'h0, 32'h0};
    int err_count, n_checks;

    hrc_top hrc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ref_osc_in(ref_osc_in),
        .ref_xtal_in(osc_cnt[0]), .wake_n_in(wake_n_in), .battery_low_in(battery_low_in),
        .regulator_enable_n(regulator_enable_n), .irq(irq));
    hrc_supply_model hrc_supply_model_i (.aclk(aclk), .regulator_enable_n(regulator_enable_n),
        .press(press), .wake_n_in(wake_n_in), .power_good(power_good));

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Slow oscillator: pulses far wider than two system cycles
    always @(posedge aclk) begin
        osc_cnt <= osc_cnt + 3'h1;
        if (osc_cnt == 3'h7) ref_osc_in <= ~ref_osc_in;
    end
    // Cuts a hang short; the whole run needs well under this
    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        complete_run();
    end

    function automatic logic exp_irq(input logic [31:0] raw, input logic [31:0] mask);
        return |(raw[3:0] & mask[3:0]);
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write through both channels; each is released at its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(rd, ed);
        chk({30'h0, rs}, {30'h0, er});
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        {battery_low_in, press} = 2'h0;
        aresetn = 1'b0;
        void'($urandom(32'h3fcdac21));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_v[i]) rdc(12'(4 * i), rst_v[i], `HRC_RESP_OKAY);
        rdc(`HRC_OFF_TRIM, 32'h7fff, `HRC_RESP_OKAY);
        rdc(12'h028, 32'h0, `HRC_RESP_SLVERR);
        wr(12'h13c, 32'h1, `HRC_RESP_SLVERR);
        wr(`HRC_OFF_COUNT, 32'h55, `HRC_RESP_OKAY);
        // Retained words: random places and contents, read back after all writes
        foreach (mem_i[i]) begin
            mem_i[i] = 6'(i * 16 + ($urandom % 16));
            mem_d[i] = $urandom;
            wr(12'h030 + 12'(mem_i[i]) * 12'h4, mem_d[i], `HRC_RESP_OKAY);
        end
        foreach (mem_i[i]) rdc(12'h030 + 12'(mem_i[i]) * 12'h4, mem_d[i], `HRC_RESP_OKAY);
        // Load while stopped: counter takes the value at once and holds it
        r = $urandom;
        m = r ^ 32'h0000_0100;
        wr(`HRC_OFF_LOAD, r, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_COUNT, r, `HRC_RESP_OKAY);
        // Match while awake becomes an interrupt, gated by the mask
        wr(`HRC_OFF_MASK, 32'h1, `HRC_RESP_OKAY);
        wr(`HRC_OFF_MATCH0, m, `HRC_RESP_OKAY);
        wr(`HRC_OFF_LOAD, m, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_RAW, 32'h1, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_MSKD, 32'h1, `HRC_RESP_OKAY);
        chk({31'h0, irq}, {31'h0, exp_irq(32'h1, 32'h1)});
        wr(`HRC_OFF_MASK, 32'h2, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_MSKD, 32'h0, `HRC_RESP_OKAY);
        chk({31'h0, irq}, {31'h0, exp_irq(32'h1, 32'h2)});
        wr(`HRC_OFF_CLR, 32'h0, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_RAW, 32'h1, `HRC_RESP_OKAY);
        wr(`HRC_OFF_CLR, 32'h1, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_RAW, 32'h0, `HRC_RESP_OKAY);
        // Low battery flag, then a refused hibernation request
        wr(`HRC_OFF_MASK, 32'h4, `HRC_RESP_OKAY);
        wr(`HRC_OFF_CTL, 32'h244, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_CTL, 32'h8000_0244, `HRC_RESP_OKAY);
        battery_low_in <= 1'b1;
        repeat (8) @(posedge aclk);
        rdc(`HRC_OFF_RAW, 32'h4, `HRC_RESP_OKAY);
        chk({31'h0, irq}, {31'h0, exp_irq(32'h4, 32'h4)});
        wr(`HRC_OFF_CTL, 32'h2d6, `HRC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, regulator_enable_n}, 32'h1);
        battery_low_in <= 1'b0;
        repeat (8) @(posedge aclk);
        wr(`HRC_OFF_CLR, 32'hf, `HRC_RESP_OKAY);
        // Pin wake; battery goes low during hibernation and must go unseen
        wr(`HRC_OFF_CTL, 32'h256, `HRC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({30'h0, regulator_enable_n, power_good}, 32'h0);
        battery_low_in <= 1'b1;
        repeat (10) @(posedge aclk);
        rdc(`HRC_OFF_RAW, 32'h0, `HRC_RESP_OKAY);
        battery_low_in <= 1'b0;
        press <= 1'b1;
        @(posedge aclk);
        press <= 1'b0;
        repeat (12) @(posedge aclk);
        chk({30'h0, regulator_enable_n, power_good}, 32'h3);
        rdc(`HRC_OFF_RAW, 32'h8, `HRC_RESP_OKAY);
        wr(`HRC_OFF_CLR, 32'h8, `HRC_RESP_OKAY);
        rdc(`HRC_OFF_RAW, 32'h0, `HRC_RESP_OKAY);
        // Match wake through the second comparator
        wr(`HRC_OFF_MATCH1, r, `HRC_RESP_OKAY);
        wr(`HRC_OFF_CTL, 32'h4e, `HRC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, regulator_enable_n}, 32'h0);
        wr(`HRC_OFF_LOAD, r, `HRC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk({31'h0, regulator_enable_n}, 32'h1);
        rdc(`HRC_OFF_RAW, 32'h2, `HRC_RESP_OKAY);
        complete_run();
    end
endmodule
